// ### rtl/sarx_regs.vh
`ifndef SARX_REGS_VH
`define SARX_REGS_VH

// Register byte offsets within the port window
`define SARX_OFF_CTRL 12'h100
`define SARX_OFF_BUFCTL 12'h104
`define SARX_OFF_BUFSTA 12'h108
`define SARX_OFF_DATA 12'h10c
`define SARX_OFF_DETCTL 12'h110
`define SARX_OFF_DETSTA 12'h114

// receiver_control fields
`define SARX_CTRL_EN 0
`define SARX_CTRL_FMT 2:1
`define SARX_CTRL_SLOT 3
`define SARX_CTRL_WIDTH 5:4
`define SARX_CTRL_SMCLK 6
`define SARX_CTRL_ROLE 7
`define SARX_CTRL_RST 8'h60

// rx_buffer_control fields
`define SARX_BCTL_RELEASE 0
`define SARX_BCTL_DEN 1
`define SARX_BCTL_IEN 2
`define SARX_BCTL_OS 5:4
`define SARX_BCTL_DMAW 7
`define SARX_BCTL_RST 8'h00

// rx_buffer_state fields
`define SARX_BSTA_ER 8
`define SARX_BSTA_IP 7
`define SARX_BSTA_EMPTY 6

// rate_detect_control fields
`define SARX_DCTL_EN 0
`define SARX_DCTL_TH 3:1
`define SARX_DCTL_TIM 5:4
`define SARX_DCTL_IE 8
`define SARX_DCTL_MUTE 12
`define SARX_DCTL_RST 13'h0000

// rate_detect_status fields
`define SARX_DSTA_TO 11
`define SARX_DSTA_SRC 10
`define SARX_DSTA_CHW 8

// Encodings
`define SARX_FMT_I2S 2'h0
`define SARX_FMT_LJ 2'h1
`define SARX_FMT_RJ 2'h2
`define SARX_FMT_TDM 2'h3
`define SARX_W16 2'h0
`define SARX_W20 2'h1
`define SARX_OS_DMA 2'h1

// Buffer geometry and timing counts
`define SARX_DEPTH 7'h20
`define SARX_HALF 7'h10
`define SARX_BCLK_HALF 4'h4

`endif

// ### rtl/sarx_sync.v
`default_nettype none

module sarx_sync #(
	parameter W = 1
) (
	input wire clk, // System clock
	input wire arst_n, // Asynchronous reset, active low
	input wire [W-1:0] din, // Foreign-domain inputs
	output reg [W-1:0] dout // Filtered, synchronised levels
);

	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;

	// Three stages; a bit moves only once stages two and three agree
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= {W{1'b0}};
			s2_reg <= {W{1'b0}};
			s3_reg <= {W{1'b0}};
			dout <= {W{1'b0}};
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			dout <= (s3_reg & ~(s2_reg ^ s3_reg)) | (dout & (s2_reg ^ s3_reg));
		end
	end

endmodule // sarx_sync

`default_nettype wire

// ### rtl/sarx_top.v
// What this block does
// - Role bit: 0 master clocks, 1 slave
// - Slave master clock: internal or pad
// - Width field: 16, 20, 24 bits
// - Slot size: 32 or 16 bit clocks
// - Format: I2S, left, right, TDM framing
// - Capture only while receiver enabled
// - DMA transfer width 32 or 16 bits
// - Consumer select: processor or DMA engine
// - Half full sets pending, irq, request
// - Buffer held reset until release written
// - Bus write while full flags error
// - 32x24 buffer, sample read in 31:8
// - Mute forces zero samples on change
// - Rate change irq only when enabled
// - Detect period two or four frames
// - Threshold is (field plus one) times 8
// - Detection only slave and enabled
// - Frame period count, cleared first enable
// - Detection timeout sets pending flag
// - Rate change sets pending flag
// - Width change sets pending flag
// - Ratio code 32/64/128/256, else error
// - Mute holds until rate pending cleared
`default_nettype none
`include "sarx_regs.vh"

module sarx_top (
	input wire clk, // System clock, 10 MHz
	input wire arst_n, // Asynchronous reset, active low
	input wire hsel, // AHB slave select
	input wire [31:0] haddr, // AHB address
	input wire [1:0] htrans, // AHB transfer type
	input wire hwrite, // AHB write
	input wire [2:0] hsize, // AHB size, words only
	input wire [31:0] hwdata, // AHB write data
	input wire hready, // AHB bus ready
	output reg [31:0] hrdata, // AHB read data
	output reg hreadyout, // AHB slave ready
	output reg hresp, // AHB response, always OKAY
	input wire bclkIn, // Bit clock pin input
	output reg bclkOut, // Bit clock pin output
	output reg bclkOe_n, // Bit clock drive enable, low drives
	input wire lrclkIn, // Frame clock pin input
	output reg lrclkOut, // Frame clock pin output
	output reg lrclkOe_n, // Frame clock drive enable, low drives
	input wire dataIn, // Serial data pin
	input wire srdClkIn, // Detection sampling clock
	output reg mclkFromPad, // Master clock mux: 1 pad, 0 internal
	output reg audioMuted, // Output path forced to zero
	output reg bufferIrq, // Half full interrupt
	output reg detectIrq, // Rate change interrupt
	output reg dmaReq, // Half full DMA request
	output reg dmaHalfWord // DMA transfer size: 1 is 16 bits
);

	reg [7:0] ctrl_reg;
	reg [7:0] bufCtl_reg;
	reg [12:0] detCtl_reg;
	reg phase_reg;
	reg wr_reg;
	reg [11:0] addr_reg;
	reg [3:0] divCnt_reg;
	reg [6:0] frameCnt_reg;
	reg bclkPrev_reg;
	reg lrPrev_reg;
	reg srdPrev_reg;
	reg lrLast_reg;
	reg armed_reg;
	reg [4:0] bitCnt_reg;
	reg [31:0] shift_reg;
	reg [23:0] mem [0:31];
	reg [5:0] wrPtr_reg;
	reg [5:0] rdPtr_reg;
	reg halfPrev_reg;
	reg halfPend_reg;
	reg bufErr_reg;
	reg started_reg;
	reg [14:0] acc_reg;
	reg [1:0] perCnt_reg;
	reg [9:0] bclkAcc_reg;
	reg [12:0] frameCount_reg;
	reg cntValid_reg;
	reg [2:0] ratio_reg;
	reg ratioValid_reg;
	reg toPend_reg;
	reg srcPend_reg;
	reg chwPend_reg;
	reg everEn_reg;
	reg enPrev_reg;
	wire [3:0] syncOut;
	wire bclkS = syncOut[0];
	wire lrS = syncOut[1];
	wire dataS = syncOut[2];
	wire srdS = syncOut[3];

	// Pins from outside the clock domain
	sarx_sync #(.W(4)) uSync (
		.clk(clk),
		.arst_n(arst_n),
		.din({srdClkIn, dataIn, lrclkIn, bclkIn}),
		.dout(syncOut)
	);

	wire receiver_enable = ctrl_reg[`SARX_CTRL_EN];
	wire slave = ctrl_reg[`SARX_CTRL_ROLE];
	wire [1:0] fmt = ctrl_reg[`SARX_CTRL_FMT];
	wire slot16 = ctrl_reg[`SARX_CTRL_SLOT];
	wire [1:0] width = ctrl_reg[`SARX_CTRL_WIDTH];
	wire isTdm = (fmt == `SARX_FMT_TDM);
	wire [4:0] slotLast = slot16 ? 5'h0f : 5'h1f;
	wire [6:0] frameLast = isTdm ? {slotLast, 2'h3} : {1'b0, slotLast, 1'b1};

	// Master bit clock is a divided system clock; frame clock moves on falling bclk
	wire divWrap = (divCnt_reg == `SARX_BCLK_HALF - 4'h1);
	wire genRise = receiver_enable & ~slave & divWrap & ~bclkOut;
	wire [6:0] frameNext = (frameCnt_reg == frameLast) ? 7'h00 : frameCnt_reg + 7'h01;
	wire firstSlot = (frameNext[6:0] <= {2'h0, slotLast});
	wire inFirstHalf = isTdm ? firstSlot : (frameNext <= {2'h0, slotLast});
	wire lrGen = (fmt == `SARX_FMT_I2S) ? ~inFirstHalf : inFirstHalf;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			divCnt_reg <= 4'h0;
			frameCnt_reg <= 7'h00;
			bclkOut <= 1'b0;
			lrclkOut <= 1'b0;
			bclkOe_n <= 1'b1;
			lrclkOe_n <= 1'b1;
			mclkFromPad <= 1'b1;
		end else begin
			bclkOe_n <= slave;
			lrclkOe_n <= slave;
			mclkFromPad <= slave & ctrl_reg[`SARX_CTRL_SMCLK];
			if (!receiver_enable || slave) begin
				divCnt_reg <= 4'h0;
				frameCnt_reg <= frameLast;
				bclkOut <= 1'b0;
				lrclkOut <= 1'b0;
			end else if (divWrap) begin
				divCnt_reg <= 4'h0;
				bclkOut <= ~bclkOut;
				if (bclkOut) begin
					frameCnt_reg <= frameNext;
					lrclkOut <= lrGen;
				end
			end else begin
				divCnt_reg <= divCnt_reg + 4'h1;
			end
		end
	end

	// Unified bit strobe for either role
	wire bitRise = slave ? (bclkS & ~bclkPrev_reg) : genRise;
	wire lrLevel = slave ? lrS : lrclkOut;
	wire lrEdge = isTdm ? (lrLevel & ~lrLast_reg) : (lrLevel ^ lrLast_reg);
	reg [4:0] bitCnt_next;
	reg [31:0] shift_next;
	reg [23:0] word;
	reg wordDone;

	// Slot position and sample extraction
	always @* begin
		shift_next = {shift_reg[30:0], dataS};
		bitCnt_next = lrEdge ? 5'h00 : (bitCnt_reg == slotLast) ? 5'h00 : bitCnt_reg + 5'h01;
		if (fmt == `SARX_FMT_I2S)
			wordDone = armed_reg & (bitCnt_next == 5'h00);
		else
			wordDone = armed_reg & (bitCnt_next == slotLast);
		if (slot16)
			word = {shift_next[15:0], 8'h00};
		else if (fmt == `SARX_FMT_RJ && width == `SARX_W16)
			word = {shift_next[15:0], 8'h00};
		else if (fmt == `SARX_FMT_RJ && width == `SARX_W20)
			word = {shift_next[19:0], 4'h0};
		else if (fmt == `SARX_FMT_RJ)
			word = shift_next[23:0];
		else
			word = shift_next[31:8];
		// Narrow samples keep their top bits only
		if (width == `SARX_W16)
			word = {word[23:8], 8'h00};
		else if (width == `SARX_W20)
			word = {word[23:4], 4'h0};
		if (audioMuted)
			word = 24'h000000;
	end

	// Right-justified with 16-bit slots is invalid, so nothing is captured
	wire fmtValid = ~(slot16 & (fmt == `SARX_FMT_RJ));
	wire pushReq = receiver_enable & bitRise & wordDone & fmtValid;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bclkPrev_reg <= 1'b0;
			lrPrev_reg <= 1'b0;
			srdPrev_reg <= 1'b0;
			lrLast_reg <= 1'b0;
			armed_reg <= 1'b0;
			bitCnt_reg <= 5'h00;
			shift_reg <= 32'h00000000;
		end else begin
			bclkPrev_reg <= bclkS;
			lrPrev_reg <= lrS;
			srdPrev_reg <= srdS;
			if (!receiver_enable) begin
				armed_reg <= 1'b0;
				bitCnt_reg <= 5'h00;
				lrLast_reg <= lrLevel;
			end else if (bitRise) begin
				lrLast_reg <= lrLevel;
				bitCnt_reg <= bitCnt_next;
				shift_reg <= shift_next;
				if (lrEdge)
					armed_reg <= 1'b1;
			end
		end
	end

	// Receive buffer: pointers one bit wider than the index
	wire [5:0] level = wrPtr_reg - rdPtr_reg;
	wire released = bufCtl_reg[`SARX_BCTL_RELEASE];
	wire empty = (level == 6'h00);
	wire full = ({1'b0, level} == `SARX_DEPTH);
	wire busAccess = phase_reg;
	wire dataRead = busAccess & ~wr_reg & (addr_reg == `SARX_OFF_DATA);
	wire dataWrite = busAccess & wr_reg & (addr_reg == `SARX_OFF_DATA);
	wire doPush = pushReq & released & ~full; // Overflowing samples are dropped
	wire doPop = dataRead & ~empty;
	wire halfLevel = ({1'b0, level} >= `SARX_HALF);
	wire [4:0] levelReport = full ? 5'h1f : level[4:0];
	wire halfW1c = busAccess & wr_reg & (addr_reg == `SARX_OFF_BUFSTA) & hwdata[`SARX_BSTA_IP];
	wire errW1c = busAccess & wr_reg & (addr_reg == `SARX_OFF_BUFSTA) & hwdata[`SARX_BSTA_ER];

	// Storage without reset; only the pointers carry state
	always @(posedge clk) begin
		if (doPush)
			mem[wrPtr_reg[4:0]] <= word;
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_reg <= 6'h00;
			rdPtr_reg <= 6'h00;
			halfPrev_reg <= 1'b0;
			halfPend_reg <= 1'b0;
			bufErr_reg <= 1'b0;
		end else begin
			if (!released) begin
				wrPtr_reg <= 6'h00;
				rdPtr_reg <= 6'h00;
			end else begin
				if (doPush)
					wrPtr_reg <= wrPtr_reg + 6'h01;
				if (doPop)
					rdPtr_reg <= rdPtr_reg + 6'h01;
			end
			halfPrev_reg <= halfLevel;
			// Set wins over a same-cycle write-one clear
			halfPend_reg <= (halfLevel & ~halfPrev_reg) | (halfPend_reg & ~halfW1c);
			bufErr_reg <= (dataWrite & full) | (bufErr_reg & ~errW1c);
		end
	end

	// Rate and width detection, slave role only
	wire detActive = receiver_enable & slave & detCtl_reg[`SARX_DCTL_EN];
	wire lrRise = lrS & ~lrPrev_reg;
	wire srdRise = srdS & ~srdPrev_reg;
	wire bRise = bclkS & ~bclkPrev_reg;
	wire [1:0] perLast = detCtl_reg[4] ? 2'h3 : 2'h1;
	wire [12:0] newCount = detCtl_reg[4] ? acc_reg[14:2] : acc_reg[13:1];
	wire [12:0] diff = (newCount > frameCount_reg) ? newCount - frameCount_reg :
		frameCount_reg - newCount;
	wire [6:0] thresh = {{1'b0, detCtl_reg[`SARX_DCTL_TH]} + 4'h1, 3'h0};
	wire endWindow = detActive & started_reg & lrRise & (perCnt_reg == perLast);
	wire rateSet = endWindow & cntValid_reg & (diff > {6'h00, thresh});
	wire timeoutSet = detActive & started_reg & ~lrRise & (acc_reg == 15'h7fff);
	reg [2:0] ratioCode;
	wire widthSet = detActive & started_reg & lrRise & ratioValid_reg & (ratioCode != ratio_reg);
	wire stW1c = busAccess & wr_reg & (addr_reg == `SARX_OFF_DETSTA);
	wire enRise = receiver_enable & ~enPrev_reg;

	// Bit clocks per frame mapped onto the ratio code
	always @* begin
		case (bclkAcc_reg)
			10'd32: ratioCode = 3'h0;
			10'd64: ratioCode = 3'h1;
			10'd128: ratioCode = 3'h2;
			10'd256: ratioCode = 3'h3;
			default: ratioCode = 3'h4;
		endcase
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			started_reg <= 1'b0;
			acc_reg <= 15'h0000;
			perCnt_reg <= 2'h0;
			bclkAcc_reg <= 10'h000;
			frameCount_reg <= 13'h0000;
			cntValid_reg <= 1'b0;
			ratio_reg <= 3'h0;
			ratioValid_reg <= 1'b0;
			everEn_reg <= 1'b0;
			enPrev_reg <= 1'b0;
		end else begin
			enPrev_reg <= receiver_enable;
			if (enRise)
				everEn_reg <= 1'b1;
			if (enRise && !everEn_reg)
				frameCount_reg <= 13'h0000;
			else if (endWindow)
				frameCount_reg <= newCount;
			if (!detActive) begin
				started_reg <= 1'b0;
				acc_reg <= 15'h0000;
				perCnt_reg <= 2'h0;
				bclkAcc_reg <= 10'h000;
				cntValid_reg <= 1'b0;
				ratioValid_reg <= 1'b0;
			end else if (lrRise) begin
				started_reg <= 1'b1;
				bclkAcc_reg <= 10'h000;
				if (started_reg) begin
					ratio_reg <= ratioCode;
					ratioValid_reg <= 1'b1;
				end
				if (!started_reg || endWindow) begin
					acc_reg <= 15'h0000;
					perCnt_reg <= 2'h0;
					cntValid_reg <= started_reg;
				end else begin
					perCnt_reg <= perCnt_reg + 2'h1;
				end
			end else if (timeoutSet) begin
				started_reg <= 1'b0; // Frame clock lost: restart the window
				acc_reg <= 15'h0000;
			end else begin
				if (srdRise)
					acc_reg <= acc_reg + 15'h0001;
				if (bRise && bclkAcc_reg != 10'h3ff)
					bclkAcc_reg <= bclkAcc_reg + 10'h001;
			end
		end
	end

	// Pending flags, mute and side outputs
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			toPend_reg <= 1'b0;
			srcPend_reg <= 1'b0;
			chwPend_reg <= 1'b0;
			audioMuted <= 1'b0;
			bufferIrq <= 1'b0;
			detectIrq <= 1'b0;
			dmaReq <= 1'b0;
			dmaHalfWord <= 1'b0;
		end else begin
			toPend_reg <= timeoutSet | (toPend_reg & ~(stW1c & hwdata[`SARX_DSTA_TO]));
			srcPend_reg <= rateSet | (srcPend_reg & ~(stW1c & hwdata[`SARX_DSTA_SRC]));
			chwPend_reg <= widthSet | (chwPend_reg & ~(stW1c & hwdata[`SARX_DSTA_CHW]));
			// Mute follows the rate pending flag so software releases both at once
			if (detCtl_reg[`SARX_DCTL_MUTE] && (rateSet || widthSet))
				audioMuted <= 1'b1;
			else if (!srcPend_reg)
				audioMuted <= 1'b0;
			detectIrq <= detCtl_reg[`SARX_DCTL_IE] & srcPend_reg;
			bufferIrq <= bufCtl_reg[`SARX_BCTL_IEN] & halfPend_reg;
			dmaReq <= bufCtl_reg[`SARX_BCTL_DEN] & halfLevel &
				(bufCtl_reg[`SARX_BCTL_OS] == `SARX_OS_DMA);
			dmaHalfWord <= bufCtl_reg[`SARX_BCTL_DMAW];
		end
	end

	// Register read mux, sampled into hrdata in the wait cycle
	reg [31:0] rdMux;
	always @* begin
		case (addr_reg)
			`SARX_OFF_CTRL: rdMux = {24'h000000, ctrl_reg};
			`SARX_OFF_BUFCTL: rdMux = {24'h000000, bufCtl_reg[7], 1'b0, bufCtl_reg[5:4], 1'b0,
				bufCtl_reg[2:0]};
			`SARX_OFF_BUFSTA: rdMux = {23'h000000, bufErr_reg, halfPend_reg, empty, 1'b0,
				levelReport};
			`SARX_OFF_DATA: rdMux = empty ? 32'h00000000 :
				{mem[rdPtr_reg[4:0]], 8'h00};
			`SARX_OFF_DETCTL: rdMux = {19'h00000, detCtl_reg};
			`SARX_OFF_DETSTA: rdMux = {7'h00, frameCount_reg, toPend_reg, srcPend_reg, 1'b0,
				chwPend_reg, 5'h00, ratio_reg};
			default: rdMux = 32'h00000000;
		endcase
	end

	// AHB-Lite slave with one wait state on every transfer
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_reg <= 1'b0;
			wr_reg <= 1'b0;
			addr_reg <= 12'h000;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ctrl_reg <= `SARX_CTRL_RST;
			bufCtl_reg <= `SARX_BCTL_RST;
			detCtl_reg <= `SARX_DCTL_RST;
		end else begin
			hresp <= 1'b0;
			if (phase_reg) begin
				phase_reg <= 1'b0;
				hreadyout <= 1'b1;
				hrdata <= wr_reg ? 32'h00000000 : rdMux;
				if (wr_reg) begin
					case (addr_reg)
						`SARX_OFF_CTRL: ctrl_reg <= hwdata[7:0];
						`SARX_OFF_BUFCTL: bufCtl_reg <= {hwdata[7], 1'b0, hwdata[5:4], 1'b0,
							hwdata[2:0]};
						`SARX_OFF_DETCTL: detCtl_reg <= {hwdata[12], 3'h0, hwdata[8], 2'h0,
							hwdata[5:0]};
						default: ctrl_reg <= ctrl_reg;
					endcase
				end
			end else if (hsel && hready && htrans[1]) begin
				phase_reg <= 1'b1;
				hreadyout <= 1'b0;
				wr_reg <= hwrite;
				addr_reg <= haddr[11:0];
			end
		end
	end

endmodule // sarx_top

`default_nettype wire

// ### tb/sarx_top_sva.sv
`default_nettype none
module sarx_chk (
	input wire logic clk, // System clock
	input wire logic arst_n, // Reset, active low
	input wire logic hsel, // Slave select
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hready, // Bus ready
	input wire logic hreadyout, // Slave ready
	input wire logic hresp, // Response code
	input wire logic [31:0] hrdata, // Read data
	input wire logic bclkOut, // Bit clock out
	input wire logic bclkOe_n, // Bit clock drive, low drives
	input wire logic lrclkOut, // Frame clock out
	input wire logic lrclkOe_n, // Frame clock drive, low drives
	input wire logic mclkFromPad // Pad master clock chosen
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// Request accepted at this edge
	wire logic taken = hsel && hready && htrans[1] && hreadyout;
	// Bus answers: one wait state, always okay, data held between transfers
	a_resp_okay: assert property (!hresp)
		else $error("error response");
	a_wait_one: assert property (taken |=> !hreadyout ##1 hreadyout)
		else $error("wait state not one cycle");
	a_wait_cause: assert property ($fell(hreadyout) |-> $past(taken))
		else $error("wait state without request");
	a_data_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata))
		else $error("read data moved outside a transfer");
	// Role decides who drives both link clocks
	a_oe_pair: assert property (bclkOe_n == lrclkOe_n)
		else $error("clock drives disagree");
	a_pad_slave: assert property (mclkFromPad |-> bclkOe_n)
		else $error("pad clock chosen as master");
	// Master bit clock holds each level four cycles
	a_bclk_half: assert property (!bclkOe_n && $changed(bclkOut) |=> $stable(bclkOut) [*3])
		else $error("bit clock half period short");
	// Frame clock only moves while the bit clock is low
	a_lr_low: assert property (!lrclkOe_n && $changed(lrclkOut) |-> !bclkOut)
		else $error("frame clock moved with bit clock high");
endmodule // sarx_chk

bind sarx_top sarx_chk chk (
	.clk(clk),
	.arst_n(arst_n),
	.hsel(hsel),
	.htrans(htrans),
	.hready(hready),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.hrdata(hrdata),
	.bclkOut(bclkOut),
	.bclkOe_n(bclkOe_n),
	.lrclkOut(lrclkOut),
	.lrclkOe_n(lrclkOe_n),
	.mclkFromPad(mclkFromPad)
);
`default_nettype wire

// ### tb/sarx_xmit.sv
`default_nettype none
module sarx_xmit (
	output logic bclk, // Bit clock toward the receiver
	output logic lrclk, // Frame clock, low for left, high for left when lj is set
	output logic dat // Serial data, MSB first
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] q[$]; // Slots, left then right
	logic [31:0] s, p;
	bit lj = 1'b0; // Left-justified framing when set
	event mark; // Early in the first queued slot
	initial begin
		bclk = 1'b0;
		lrclk = 1'b1;
		dat = 1'b0;
		p = 32'h0;
	end
	// Junk lead frame, queued frames, then a cut slot carrying the last LSB when lj is clear;
	// the clock then stands still and data shows the inverse of its last bit
	task automatic send(input int nf);
		#13; // Keep pin changes off the system clock edge
		for (int f = 0; f < 2 * nf + 3; f++) begin
			s = (f < 2 || f > 2 * nf + 1) ? $urandom : q.pop_front();
			for (int b = 0; b < 32 && (f < 2 * nf + 2 || b < 9); b++) begin
				#400 bclk = 1'b0;
				lrclk = f[0] ^ lj;
				dat = lj ? s[31 - b] : (b ? s[32 - b] : p[0]);
				if (f == 2 && b == 8)
					-> mark;
				#400 bclk = 1'b1;
			end
			p = s;
		end
		dat = ~dat;
	endtask
endmodule // sarx_xmit
`default_nettype wire

// ### tb/sarx_top_tb.sv
`default_nettype none
module sarx_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, arst_n, hsel, hwrite, detection_sampling_clock;
	logic [31:0] haddr, hwdata, rd, v;
	logic [1:0] htrans;
	wire logic [31:0] hrdata;
	wire logic hready, hreadyout, hresp, bclkOut, bclkOe_n, lrclkOut, lrclkOe_n;
	wire logic mclkFromPad, audioMuted, bufferIrq, detectIrq, dmaReq, dmaHalfWord;
	wire logic xmBclk, xmLr, xmDat;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	logic [31:0] bctl = 32'h17; // Released, both requests on, DMA consumer
	logic [31:0] mdl[$]; // Expected buffer words in order
	sarx_top uut (
		.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .bclkIn(bclkOe_n ? xmBclk : bclkOut),
		.bclkOut(bclkOut), .bclkOe_n(bclkOe_n), .lrclkIn(lrclkOe_n ? xmLr : lrclkOut),
		.lrclkOut(lrclkOut), .lrclkOe_n(lrclkOe_n), .dataIn(xmDat), .srdClkIn(detection_sampling_clock),
		.mclkFromPad(mclkFromPad), .audioMuted(audioMuted), .bufferIrq(bufferIrq),
		.detectIrq(detectIrq), .dmaReq(dmaReq), .dmaHalfWord(dmaHalfWord)
	);
	sarx_xmit xm (.bclk(xmBclk), .lrclk(xmLr), .dat(xmDat));
	assign hready = hreadyout; // Single slave drives bus ready
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Detection sampling clock, free running, unrelated in phase
	initial begin
		detection_sampling_clock = 1'b0;
		forever #730 detection_sampling_clock = ~detection_sampling_clock;
	end
	// Hang guard, well above the expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic pin(input string nm, input logic e, input logic s);
		cmp(nm, {31'h0, e}, {31'h0, s});
	endtask
	// Address phase held until ready, then data phase until ready
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		do
			@(posedge clk);
		while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do
			@(posedge clk);
		while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		cmp(nm, e, rd);
	endtask
	task automatic drain(input int k);
		for (int i = 0; i < k; i++)
			rchk("sample", 12'h10c, mdl.size() ? mdl.pop_front() : 32'h0);
	endtask
	// Queue frames, flush the buffer early in the first one, so only they count
	task automatic burst(input int nf, input int bits, input bit keep);
		logic [31:0] s;
		mdl.delete();
		for (int i = 0; i < 2 * nf; i++) begin
			s = $urandom;
			xm.q.push_back(s);
			// Top bits kept left aligned, rest zero; full buffer drops
			if (keep && mdl.size() < 32)
				mdl.push_back({s[31:8] & (24'hffffff << (24 - bits)), 8'h00});
		end
		fork
			xm.send(nf);
			begin
				@(xm.mark);
				ahb(1'b1, 12'h104, bctl & 32'hfffffffe);
				ahb(1'b0, 12'h108, 32'h0);
				cmp("held state", 32'h40, rd & 32'h5f);
				ahb(1'b1, 12'h104, bctl);
				if (nf > 4) begin
					repeat (600) @(posedge clk);
					ahb(1'b0, 12'h114, 32'h0);
					cmp("ratio", 32'h1, rd & 32'h7);
				end
			end
		join
		repeat (10) @(posedge clk);
	endtask
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		arst_n = 1'b0;
		void'($urandom(32'hfec11bba));
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		rchk("control", 12'h100, 32'h60);
		rchk("buffer control", 12'h104, 32'h0);
		rchk("buffer state", 12'h108, 32'h40);
		rchk("detect control", 12'h110, 32'h0);
		rchk("detect status", 12'h114, 32'h0);
		rchk("unmapped", 12'h118, 32'h0);
		// Writable fields read back, reserved codes avoided
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			ahb(1'b1, 12'h104, v & 32'h96);
			rchk("buffer control", 12'h104, v & 32'h96);
			pin("dma width", v[7], dmaHalfWord);
			ahb(1'b1, 12'h110, v & 32'h111e);
			rchk("detect control", 12'h110, v & 32'h111e);
		end
		for (int f = 0; f < 4; f++) begin
			ahb(1'b1, 12'h100, 32'hc8 | (f << 1));
			rchk("format", 12'h100, 32'hc8 | (f << 1));
		end
		ahb(1'b1, 12'h110, 32'h1);
		ahb(1'b1, 12'h104, bctl);
		ahb(1'b1, 12'h100, 32'he1);
		repeat (2) @(posedge clk);
		pin("pad clock", 1'b1, mclkFromPad);
		pin("bit clock drive", 1'b1, bclkOe_n);
		// Widths 16, 20 and 24 from 32-bit slots
		for (int f = 0; f < 3; f++) begin
			ahb(1'b1, 12'h100, 32'hc1 | (f << 4));
			burst(2, 16 + 4 * f, 1'b1);
			drain(4);
		end
		// Half full: flag, interrupt and request
		ahb(1'b1, 12'h108, 32'h180);
		burst(8, 24, 1'b1);
		rchk("half state", 12'h108, 32'h90);
		pin("half irq", 1'b1, bufferIrq);
		pin("dma request", 1'b1, dmaReq);
		drain(1);
		repeat (3) @(posedge clk);
		pin("dma request", 1'b0, dmaReq);
		ahb(1'b1, 12'h108, 32'h80);
		repeat (2) @(posedge clk);
		pin("half irq", 1'b0, bufferIrq);
		drain(16);
		// Overfilled buffer, then a bus write into it
		burst(17, 24, 1'b1);
		rchk("full state", 12'h108, 32'h9f);
		ahb(1'b1, 12'h10c, 32'h0);
		rchk("error state", 12'h108, 32'h19f);
		ahb(1'b1, 12'h108, 32'h180);
		rchk("cleared state", 12'h108, 32'h1f);
		drain(33);
		rchk("drained state", 12'h108, 32'h40);
		// Left justified: MSB on the frame edge, frame high first
		xm.lj = 1'b1;
		ahb(1'b1, 12'h100, 32'he3);
		burst(2, 24, 1'b1);
		drain(4);
		xm.lj = 1'b0;
		// A stalled frame clock stretches one window: rate, width, mute, irq
		ahb(1'b1, 12'h100, 32'he1);
		ahb(1'b1, 12'h110, 32'h1101);
		ahb(1'b1, 12'h114, 32'hd00);
		repeat (1000) @(posedge clk);
		burst(5, 24, 1'b0);
		ahb(1'b0, 12'h114, 32'h0);
		cmp("detect flags", 32'h500, rd & 32'h500);
		pin("rate irq", 1'b1, detectIrq);
		pin("mute", 1'b1, audioMuted);
		ahb(1'b1, 12'h114, 32'h500);
		repeat (2) @(posedge clk);
		pin("mute", 1'b0, audioMuted);
		pin("rate irq", 1'b0, detectIrq);
		// Right justified with short slots takes nothing
		ahb(1'b1, 12'h100, 32'hed);
		burst(2, 24, 1'b0);
		rchk("nothing taken", 12'h108, 32'h40);
		// Master role: we drive both clocks; left running to the end
		ahb(1'b1, 12'h110, 32'h0);
		ahb(1'b1, 12'h100, 32'h21);
		repeat (20) @(posedge clk);
		pin("bit clock drive", 1'b0, bclkOe_n);
		pin("pad clock", 1'b0, mclkFromPad);
		n = 0;
		v[0] = bclkOut;
		for (int i = 0; i < 80; i++) begin
			@(posedge clk);
			n += (bclkOut !== v[0]);
			v[0] = bclkOut;
		end
		cmp("bit clock edges", 32'd20, 32'(n));
		conclude();
	end
endmodule // sarx_top_tb
`default_nettype wire
